// ==== rtl/axis_home_regs.vh ====
// register offsets, field positions, reset values, error codes and timing for the homing axis
// assumes a 50 MHz clock and 32-bit word-aligned AXI4-Lite register access
`ifndef AXIS_HOME_REGS_VH
`define AXIS_HOME_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define TICK_NS 1000000
`define ACC_STEP_DEF 16'h0040
`define POS_SLOW_DEF 32'h00000010
`define SPEED_MIN 16'h0001

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_CONFIG 8'h04
`define REG_HOME_SPEED 8'h08
`define REG_CREEP_SPEED 8'h0C
`define REG_SPEED_LIMIT 8'h10
`define REG_JOG_SPEED 8'h14
`define REG_NEW_SPEED 8'h18
`define REG_POS_SPEED 8'h1C
`define REG_TARGET 8'h20
`define REG_SOFT_UPPER 8'h24
`define REG_SOFT_LOWER 8'h28
`define REG_POST_DOG 8'h2C
`define REG_DWELL_MS 8'h30
`define REG_STATUS 8'h34
`define REG_FEED 8'h38
`define REG_ERROR 8'h3C
`define REG_IRQ_STATUS 8'h40
`define REG_IRQ_MASK 8'h44

// ----------------------------------------
// control bits (write one to act, except jog run and jog direction)
// ----------------------------------------
`define CTRL_HOME_START 0
`define CTRL_JOG_RUN 1
`define CTRL_JOG_DIR 2
`define CTRL_POS_START 3
`define CTRL_SPEED_CHG 4
`define CTRL_STOP 5
`define CTRL_ERR_CLR 6

// ----------------------------------------
// config fields
// ----------------------------------------
`define CFG_METHOD_LO 0
`define CFG_METHOD_HI 1
`define CFG_HOME_REV 2
`define CFG_LIMIT_SEL 3
`define CFG_RESET 4'h0
`define METHOD_DOG 2'h0
`define METHOD_CNT1 2'h1
`define METHOD_CNT2 2'h2

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_HOME_DONE 0
`define IRQ_POS_DONE 1
`define IRQ_ERROR 2
`define IRQ_RETRY 3
`define IRQ_W 4

// ----------------------------------------
// error codes
// ----------------------------------------
`define ERR_NONE 16'h0000
`define ERR_HW_UPPER 16'd1100
`define ERR_HW_LOWER 16'd1101
`define ERR_RETRY 16'd1202
`define ERR_SOFT_LIMIT 16'h0F01

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPEED_RESET 16'h0000
`define WORD_RESET 32'h00000000
`define SOFT_UPPER_RESET 32'h7FFFFFFF
`define SOFT_LOWER_RESET 32'h80000000

`endif

// ==== rtl/step_rate_gen.v ====
// phase accumulator turning a speed word into one-cycle step pulses
// assumes speed is in steps per 2^24 clock cycles and changes only between cycles
`timescale 1ns/1ns

module step_rate_gen #(
  parameter ACC_W = 24,
  parameter SPD_W = 16
) (
  input wire clk,
  input wire resetn,
  input wire [SPD_W-1:0] speed,
  output reg step
);

  reg [ACC_W-1:0] acc;
  wire [ACC_W:0] sum;

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  // carry out of the accumulator is the step; speed zero never steps
  assign sum = {1'b0, acc} + {{(ACC_W+1-SPD_W){1'b0}}, speed};

  always @(posedge clk) begin
    if (!resetn) begin
      acc <= {ACC_W{1'b0}};
      step <= 1'b0;
    end else begin
      acc <= sum[ACC_W-1:0];
      step <= sum[ACC_W];
    end
  end

endmodule // step_rate_gen

// ==== rtl/axis_home_return_retry.v ====
// single-axis homing with retry, stroke limits, speed clamp, jog and positioning
// assumes switch inputs synchronous to clk; limit inputs high while inside range
// Functional notes
// - retry applies for dog, count one, count two
// - home start moves axis in homing direction
// - homing limit off edge starts deceleration
// - after stop, dwell then reverse at homing speed
// - reverse travel decelerates on dog off edge
// - after dog stop, dwell then home again
// - dog method completes on zero after dog off
// - count one completes on zero after amount
// - count two completes at amount, slowing from creep
// - beyond range, origin ahead: refuse, error 1100/1101
// - soft limits refuse positioning start and stop positioning and jog
// - limit switch off decelerates axis to stop in positioning and jog, and on the opposite limit in homing run and creep
// - clamp requested speed to speed limit
// - speed change accepted during jog
// - target may change while positioning
// - beyond range, origin behind: reverse past dog, home
// - limit off over dog at start, dog method only: error 1202
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "axis_home_regs.vh"

module axis_home_return_retry #(
  parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
  parameter [15:0] ACC_STEP = `ACC_STEP_DEF,
  parameter [31:0] POS_SLOW = `POS_SLOW_DEF
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire limit_upper,
  input wire limit_lower,
  input wire near_dog,
  input wire zero_sig,
  output reg pulse_out,
  output reg dir_out,
  output reg irq
);

  localparam ST_IDLE = 4'h0;
  localparam ST_H_RUN = 4'h1;
  localparam ST_H_LIMSTOP = 4'h2;
  localparam ST_H_DWELL_R = 4'h3;
  localparam ST_H_REV = 4'h4;
  localparam ST_H_DOGSTOP = 4'h5;
  localparam ST_H_DWELL_F = 4'h6;
  localparam ST_H_CREEP = 4'h7;
  localparam ST_POS = 4'h8;
  localparam ST_JOG = 4'h9;
  localparam ST_STOP = 4'hA;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [3:0] cfg;
  reg [15:0] home_speed, creep_speed, speed_limit, jog_speed, new_speed, pos_speed, dwell_ms;
  reg [31:0] target, soft_upper, soft_lower, post_dog;
  reg jog_run, jog_dir;
  reg [`IRQ_W-1:0] irq_status, irq_mask;
  reg [15:0] err_code;
  reg [7:0] wr_addr;
  reg aw_have, w_have;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg cmd_home, cmd_pos, cmd_chg, cmd_stop, cmd_clr;

  // motion state
  reg [3:0] state;
  reg signed [31:0] feed, dog_pos;
  reg mv_dir;
  reg [15:0] goal, cur_speed, jog_eff;
  reg [31:0] tick_cnt;
  reg tick;
  reg [15:0] dwell_cnt;
  reg dog_q, zero_q, lim_home_q, dog_off_seen, kill;
  reg ev_home, ev_pos, ev_err, ev_retry;
  wire step;

  wire [1:0] method = cfg[`CFG_METHOD_HI:`CFG_METHOD_LO];
  wire home_fwd = ~cfg[`CFG_HOME_REV];
  wire retry_en = cfg[`CFG_LIMIT_SEL];
  wire lim_home = home_fwd ? limit_upper : limit_lower;
  wire lim_opp = home_fwd ? limit_lower : limit_upper;
  wire [15:0] opp_err = home_fwd ? `ERR_HW_LOWER : `ERR_HW_UPPER;
  wire lim_mv = mv_dir ? limit_upper : limit_lower;
  wire [15:0] mv_err = mv_dir ? `ERR_HW_UPPER : `ERR_HW_LOWER;
  wire stopped = (cur_speed == 16'h0000);
  wire dwell_done = (dwell_cnt == 16'h0000);

  // speed requests never exceed the limit
  wire [15:0] home_lim = (home_speed > speed_limit) ? speed_limit : home_speed;
  wire [15:0] creep_lim = (creep_speed > speed_limit) ? speed_limit : creep_speed;
  wire [15:0] pos_lim = (pos_speed > speed_limit) ? speed_limit : pos_speed;
  wire [15:0] jog_lim = (jog_eff > speed_limit) ? speed_limit : jog_eff;
  wire [15:0] chg_lim = (new_speed > speed_limit) ? speed_limit : new_speed;

  // distance since dog turned on, and distance left to the target
  wire [31:0] travel = mv_dir ? feed - dog_pos : dog_pos - feed;
  wire amt_reached = (travel >= post_dog);
  wire [31:0] amt_left = post_dog - travel;
  wire signed [31:0] tgt_s = target;
  wire want_fwd = (tgt_s > feed);
  wire [31:0] tgt_dist = want_fwd ? tgt_s - feed : feed - tgt_s;
  wire tgt_out = (tgt_s > $signed(soft_upper)) || (tgt_s < $signed(soft_lower));
  wire feed_out = (feed > $signed(soft_upper)) || (feed < $signed(soft_lower));
  wire moving_ctl = (state == ST_POS) || (state == ST_JOG);

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // address and data are taken in either order; response after both
  always @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= `WORD_RESET;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr > `REG_IRQ_MASK || wr_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  wire do_wr = aw_have && w_have && !s_axi_bvalid;

  // register writes; byte lane zero gates every register write
  always @(posedge clk) begin
    if (!resetn) begin
      cfg <= `CFG_RESET;
      home_speed <= `SPEED_RESET;
      creep_speed <= `SPEED_RESET;
      speed_limit <= `SPEED_RESET;
      jog_speed <= `SPEED_RESET;
      new_speed <= `SPEED_RESET;
      pos_speed <= `SPEED_RESET;
      dwell_ms <= `SPEED_RESET;
      target <= `WORD_RESET;
      soft_upper <= `SOFT_UPPER_RESET;
      soft_lower <= `SOFT_LOWER_RESET;
      post_dog <= `WORD_RESET;
      irq_mask <= {`IRQ_W{1'b0}};
      jog_run <= 1'b0;
      jog_dir <= 1'b0;
      {cmd_home, cmd_pos, cmd_chg, cmd_stop, cmd_clr} <= 5'h00;
    end else begin
      {cmd_home, cmd_pos, cmd_chg, cmd_stop, cmd_clr} <= 5'h00;
      if (do_wr && wr_strb[0]) begin
        case (wr_addr)
          `REG_CTRL: begin
            cmd_home <= wr_data[`CTRL_HOME_START];
            jog_run <= wr_data[`CTRL_JOG_RUN];
            jog_dir <= wr_data[`CTRL_JOG_DIR];
            cmd_pos <= wr_data[`CTRL_POS_START];
            cmd_chg <= wr_data[`CTRL_SPEED_CHG];
            cmd_stop <= wr_data[`CTRL_STOP];
            cmd_clr <= wr_data[`CTRL_ERR_CLR];
          end
          `REG_CONFIG: cfg <= wr_data[3:0];
          `REG_HOME_SPEED: home_speed <= wr_data[15:0];
          `REG_CREEP_SPEED: creep_speed <= wr_data[15:0];
          `REG_SPEED_LIMIT: speed_limit <= wr_data[15:0];
          `REG_JOG_SPEED: jog_speed <= wr_data[15:0];
          `REG_NEW_SPEED: new_speed <= wr_data[15:0];
          `REG_POS_SPEED: pos_speed <= wr_data[15:0];
          `REG_TARGET: target <= wr_data;
          `REG_SOFT_UPPER: soft_upper <= wr_data;
          `REG_SOFT_LOWER: soft_lower <= wr_data;
          `REG_POST_DOG: post_dog <= wr_data;
          `REG_DWELL_MS: dwell_ms <= wr_data[15:0];
          `REG_IRQ_MASK: irq_mask <= wr_data[`IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel and interrupts
  // ----------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: rd_mux = {29'h0, jog_dir, jog_run, 1'b0};
      `REG_CONFIG: rd_mux = {28'h0, cfg};
      `REG_HOME_SPEED: rd_mux = {16'h0000, home_speed};
      `REG_CREEP_SPEED: rd_mux = {16'h0000, creep_speed};
      `REG_SPEED_LIMIT: rd_mux = {16'h0000, speed_limit};
      `REG_JOG_SPEED: rd_mux = {16'h0000, jog_speed};
      `REG_NEW_SPEED: rd_mux = {16'h0000, new_speed};
      `REG_POS_SPEED: rd_mux = {16'h0000, pos_speed};
      `REG_TARGET: rd_mux = target;
      `REG_SOFT_UPPER: rd_mux = soft_upper;
      `REG_SOFT_LOWER: rd_mux = soft_lower;
      `REG_POST_DOG: rd_mux = post_dog;
      `REG_DWELL_MS: rd_mux = {16'h0000, dwell_ms};
      `REG_STATUS: rd_mux = {cur_speed, 10'h000, mv_dir, (state != ST_IDLE), state};
      `REG_FEED: rd_mux = feed;
      `REG_ERROR: rd_mux = {16'h0000, err_code};
      `REG_IRQ_STATUS: rd_mux = {28'h0, irq_status};
      `REG_IRQ_MASK: rd_mux = {28'h0, irq_mask};
      default: begin
        rd_mux = `WORD_RESET;
        rd_ok = 1'b0;
      end
    endcase
  end

  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire irq_clr = rd_take && (s_axi_araddr == `REG_IRQ_STATUS);
  wire [`IRQ_W-1:0] irq_ev = {ev_retry, ev_err, ev_pos, ev_home};
  wire [`IRQ_W-1:0] next_irq_status = (irq_clr ? {`IRQ_W{1'b0}} : irq_status) | irq_ev;

  // a read of the interrupt status register clears the sticky bits, but an event in that cycle survives
  always @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `WORD_RESET;
      s_axi_rresp <= 2'b00;
      irq_status <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // millisecond tick and speed ramp
  // ----------------------------------------
  // ramp steps once per tick; kill drops speed at once when the origin is found
  always @(posedge clk) begin
    if (!resetn) begin
      tick_cnt <= `WORD_RESET;
      tick <= 1'b0;
      cur_speed <= `SPEED_RESET;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? `WORD_RESET : tick_cnt + 32'h1;
      if (kill)
        cur_speed <= `SPEED_RESET;
      else if (tick) begin
        if (goal > cur_speed)
          cur_speed <= (goal - cur_speed > ACC_STEP) ? cur_speed + ACC_STEP : goal;
        else
          cur_speed <= (cur_speed - goal > ACC_STEP) ? cur_speed - ACC_STEP : goal;
      end
    end
  end

  step_rate_gen #(.ACC_W(24), .SPD_W(16)) u_rate (
    .clk(clk),
    .resetn(resetn),
    .speed(cur_speed),
    .step(step)
  );

  // ----------------------------------------
  // motion sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      feed <= `WORD_RESET;
      dog_pos <= `WORD_RESET;
      mv_dir <= 1'b1;
      goal <= `SPEED_RESET;
      jog_eff <= `SPEED_RESET;
      dwell_cnt <= `SPEED_RESET;
      err_code <= `ERR_NONE;
      {dog_q, zero_q, lim_home_q, dog_off_seen, kill} <= 5'h00;
      {ev_home, ev_pos, ev_err, ev_retry} <= 4'h0;
      pulse_out <= 1'b0;
      dir_out <= 1'b1;
    end else begin
      dog_q <= near_dog;
      zero_q <= zero_sig;
      lim_home_q <= lim_home;
      kill <= 1'b0;
      {ev_home, ev_pos, ev_err, ev_retry} <= 4'h0;
      pulse_out <= step;
      dir_out <= mv_dir;
      if (step)
        feed <= mv_dir ? feed + 32'sd1 : feed - 32'sd1;
      if (tick && !dwell_done)
        dwell_cnt <= dwell_cnt - 16'h0001;
      if (cmd_clr)
        err_code <= `ERR_NONE;
      case (state)
        ST_IDLE: begin
          goal <= `SPEED_RESET;
          dog_off_seen <= 1'b0;
          if (err_code != `ERR_NONE) begin
          end else if (cmd_home) begin
            mv_dir <= home_fwd;
            if (!lim_opp) begin
              err_code <= opp_err;
              ev_err <= 1'b1;
            end else if (!lim_home && near_dog && method == `METHOD_DOG) begin
              err_code <= `ERR_RETRY;
              ev_err <= 1'b1;
            end else if (!lim_home && retry_en) begin
              mv_dir <= ~home_fwd;
              goal <= home_lim;
              ev_retry <= 1'b1;
              state <= ST_H_REV;
            end else if (near_dog && method == `METHOD_DOG) begin
              dog_pos <= feed;
              goal <= creep_lim;
              state <= ST_H_CREEP;
            end else if (near_dog && retry_en) begin
              mv_dir <= ~home_fwd;
              goal <= home_lim;
              ev_retry <= 1'b1;
              state <= ST_H_REV;
            end else begin
              goal <= home_lim;
              state <= ST_H_RUN;
            end
          end else if (cmd_pos) begin
            if (tgt_out) begin
              err_code <= `ERR_SOFT_LIMIT;
              ev_err <= 1'b1;
            end else if (tgt_s == feed) begin
              ev_pos <= 1'b1;
            end else begin
              mv_dir <= want_fwd;
              state <= ST_POS;
            end
          end else if (jog_run) begin
            mv_dir <= jog_dir;
            jog_eff <= jog_speed;
            state <= ST_JOG;
          end
        end
        ST_H_RUN: begin
          if (!lim_opp) begin
            err_code <= opp_err;
            ev_err <= 1'b1;
            state <= ST_STOP;
          end else if (retry_en && lim_home_q && !lim_home) begin
            goal <= `SPEED_RESET;
            ev_retry <= 1'b1;
            state <= ST_H_LIMSTOP;
          end else if (near_dog && !dog_q) begin
            dog_pos <= feed;
            dog_off_seen <= 1'b0;
            goal <= creep_lim;
            state <= ST_H_CREEP;
          end
        end
        ST_H_LIMSTOP: begin
          if (stopped) begin
            dwell_cnt <= dwell_ms;
            state <= ST_H_DWELL_R;
          end
        end
        ST_H_DWELL_R: begin
          if (dwell_done) begin
            mv_dir <= ~home_fwd;
            goal <= home_lim;
            state <= ST_H_REV;
          end
        end
        ST_H_REV: begin
          if (dog_q && !near_dog) begin
            goal <= `SPEED_RESET;
            state <= ST_H_DOGSTOP;
          end
        end
        ST_H_DOGSTOP: begin
          if (stopped) begin
            dwell_cnt <= dwell_ms;
            state <= ST_H_DWELL_F;
          end
        end
        ST_H_DWELL_F: begin
          if (dwell_done) begin
            mv_dir <= home_fwd;
            goal <= home_lim;
            state <= ST_H_RUN;
          end
        end
        ST_H_CREEP: begin
          if (dog_q && !near_dog)
            dog_off_seen <= 1'b1;
          if (!lim_opp) begin
            err_code <= opp_err;
            ev_err <= 1'b1;
            state <= ST_STOP;
          end else if ((method == `METHOD_DOG && dog_off_seen && zero_sig && !zero_q) ||
                       (method == `METHOD_CNT1 && amt_reached && zero_sig && !zero_q) ||
                       (method == `METHOD_CNT2 && amt_reached)) begin
            kill <= 1'b1;
            goal <= `SPEED_RESET;
            feed <= `WORD_RESET;
            ev_home <= 1'b1;
            state <= ST_IDLE;
          end else if (method == `METHOD_CNT2 && amt_left <= POS_SLOW) begin
            goal <= `SPEED_MIN;
          end
        end
        ST_POS: begin
          if (want_fwd != mv_dir || tgt_s == feed) begin
            goal <= `SPEED_RESET;
            if (stopped && tgt_s == feed) begin
              ev_pos <= 1'b1;
              state <= ST_IDLE;
            end else if (stopped)
              mv_dir <= want_fwd;
          end else
            goal <= (tgt_dist <= POS_SLOW) ? `SPEED_MIN : pos_lim;
        end
        ST_JOG: begin
          goal <= jog_lim;
          if (cmd_chg)
            jog_eff <= new_speed;
          if (!jog_run)
            state <= ST_STOP;
        end
        ST_STOP: begin
          goal <= `SPEED_RESET;
          if (stopped)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // supervision common to positioning and jog
      if (moving_ctl) begin
        if (!lim_mv) begin
          err_code <= mv_err;
          ev_err <= 1'b1;
          goal <= `SPEED_RESET;
          state <= ST_STOP;
        end else if (feed_out) begin
          err_code <= `ERR_SOFT_LIMIT;
          ev_err <= 1'b1;
          goal <= `SPEED_RESET;
          state <= ST_STOP;
        end
      end
      if (cmd_stop && state != ST_IDLE) begin
        goal <= `SPEED_RESET;
        state <= ST_STOP;
      end
    end
  end

  // jog speed change applied with clamp after the new word lands
  wire unused_chg = chg_lim[0];

endmodule // axis_home_return_retry

// ==== bench/axis_far_side.sv ====
// far-side model: limit switches, near-point dog and zero marks on a step-counted axis
// assumes pulse_out and dir_out of the axis, sampled on clk
`timescale 1ns/1ns
module axis_far_side #(
  parameter integer UP = 20,
  parameter integer LO = -20
) (
  input wire clk,
  input wire pulse_out,
  input wire dir_out,
  output wire limit_upper,
  output wire limit_lower,
  output wire near_dog,
  output reg zero_sig = 1'b0
);
  integer pos = 0;
  integer nxt;
  // switches open past the stroke ends, dog closed over steps 8 to 11
  assign limit_upper = pos < UP;
  assign limit_lower = pos > LO;
  assign near_dog = pos >= 8 && pos <= 11;
  // one-cycle zero mark on arriving at every fourth step
  always @(posedge clk) begin
    nxt = dir_out ? pos + 1 : pos - 1;
    zero_sig <= pulse_out && ((nxt & 3) == 2);
    if (pulse_out)
      pos <= nxt;
  end
endmodule // axis_far_side

// ==== bench/axis_home_return_retry_sva.sv ====
// port checker for the homing axis
// assumes binding to the design top, tick parameter handed on
`timescale 1ns/1ns
module axis_home_return_retry_sva #(
  parameter TICK_CYCLES = 50000
) (
  input wire clk,
  input wire resetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire limit_upper,
  input wire limit_lower,
  input wire pulse_out,
  input wire dir_out,
  input wire irq
);
  // full ramp-down from top speed plus one step period of slack
  localparam integer DECEL_MAX = 1100 * TICK_CYCLES + 300;
  integer cnt_up;
  integer cnt_dn;
  // cycles spent pointing into an open limit
  always @(posedge clk) begin
    cnt_up <= (!resetn || limit_upper || !dir_out) ? 0 : cnt_up + 1;
    cnt_dn <= (!resetn || limit_lower || dir_out) ? 0 : cnt_dn + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer changed");
  step_gap_a: assert property (pulse_out |=> !pulse_out [*8]) else $error("steps too close");
  dir_turn_a: assert property ($changed(dir_out) |-> !pulse_out ##1 !pulse_out [*8])
    else $error("direction turned while moving");
  upper_stop_a: assert property (cnt_up >= DECEL_MAX |-> !pulse_out)
    else $error("still stepping into upper limit");
  lower_stop_a: assert property (cnt_dn >= DECEL_MAX |-> !pulse_out)
    else $error("still stepping into lower limit");
  cover property (pulse_out && !dir_out);
  cover property (irq);
  cover property (cnt_up >= DECEL_MAX);
endmodule // axis_home_return_retry_sva

bind axis_home_return_retry axis_home_return_retry_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (.*);

// ==== bench/tb_axis_home_return_retry.sv ====
// self-checking bench for the homing axis
// assumes the far-side model and the checker compile first
`timescale 1ns/1ns
`include "axis_home_regs.vh"
module tb_axis_home_return_retry;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire limit_upper, limit_lower, near_dog, zero_sig, pulse_out, dir_out, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg [31:0] d;
  reg [1:0] r;
  integer fails = 0, tests_run = 0, cycles = 0, m;
  axis_home_return_retry #(.TICK_CYCLES(1)) i_axis_home_return_retry (.*);
  axis_far_side i_axis_far_side (.*);
  // ----------------------------------------
  // clock, timeout and common tasks
  // ----------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      $display("checks %0d errors %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] n, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  // request held until its own ready, answer taken at its valid
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_home(input [1:0] meth);
    integer k;
    reg [31:0] seen;
    begin
      seen = 32'h0;
      i_axis_far_side.pos <= 14;
      wr(`REG_CONFIG, {28'h0, 2'b10, meth});
      wr(`REG_CTRL, 32'h1);
      for (k = 0; k < 20000 && !seen[0]; k = k + 1) begin
        @(posedge clk);
        if (irq === 1'b1) begin
          rd(`REG_IRQ_STATUS);
          seen = seen | d;
        end
      end
      chk("done", seen & 32'h9, 32'h9);
      if (meth == `METHOD_DOG)
        chk("pos", i_axis_far_side.pos, 32'd14);
      rd(`REG_ERROR);
      chk("err", d, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
    end
  endtask
  task s_refuse;
    begin
      i_axis_far_side.pos <= 30;
      wr(`REG_CONFIG, 32'hC);
      wr(`REG_CTRL, 32'h1);
      rd(`REG_ERROR);
      chk("hw_err", d, {16'h0, `ERR_HW_UPPER});
      chk("hw_pos", i_axis_far_side.pos, 32'd30);
      wr(`REG_CTRL, 32'h40);
    end
  endtask
  // jog into a stroke end, then stay past the ramp-down window
  task s_jog(input fwd);
    integer k;
    begin
      i_axis_far_side.pos <= fwd ? 14 : -14;
      wr(`REG_CTRL, {29'h0, fwd, 2'b10});
      for (k = 0; k < 9000 && (fwd ? limit_upper : limit_lower) === 1'b1; k = k + 1)
        @(posedge clk);
      repeat (1500) @(posedge clk);
      k = i_axis_far_side.pos;
      rd(`REG_ERROR);
      chk("jog_err", d, fwd ? {16'h0, `ERR_HW_UPPER} : {16'h0, `ERR_HW_LOWER});
      repeat (600) @(posedge clk);
      chk("jog_pos", i_axis_far_side.pos, k);
      wr(`REG_CTRL, 32'h40);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(`REG_SOFT_UPPER);
    chk("soft_up", d, `SOFT_UPPER_RESET);
    rd(8'h48);
    chk("unmapped", {30'h0, r}, 32'h2);
    wr(8'h48, 32'h0);
    chk("unm_wr", {30'h0, r}, 32'h2);
    wr(`REG_HOME_SPEED, 32'hFFFF);
    wr(`REG_CREEP_SPEED, 32'h8000);
    wr(`REG_SPEED_LIMIT, 32'hFFFF);
    wr(`REG_JOG_SPEED, 32'hFFFF);
    wr(`REG_POST_DOG, 32'h2);
    wr(`REG_DWELL_MS, 32'h3);
    wr(`REG_IRQ_MASK, 32'hF);
    for (m = 0; m < 3; m = m + 1)
      s_home(m[1:0]);
    s_refuse;
    s_jog(1'b1);
    s_jog(1'b0);
    end_of_test;
  end
endmodule // tb_axis_home_return_retry
